// ==== bench/lps_led_model.sv ====
// lps_led_model.sv: board side of the two indicator pins.
// Assumes the dut splits each pin into level and enable.
`timescale 1ns/1ps
`default_nettype none
module lps_led_model (
	// dut side
	input  wire logic pri_lvl_in,
	input  wire logic pri_oe_in,
	input  wire logic sec_lvl_in,
	input  wire logic sec_oe_in,
	// wire levels fed back
	output wire logic pri_pin_out,
	output wire logic sec_pin_out
);
	// released pins settle to the board pulls: up on primary, down on secondary
	assign pri_pin_out = pri_oe_in ? pri_lvl_in : 1'b1;
	assign sec_pin_out = sec_oe_in ? sec_lvl_in : 1'b0;
endmodule // lps_led_model
`default_nettype wire

// ==== bench/lps_top_assertions.sv ====
// lps_top_assertions.sv: port checks bound into lps_top.
// Assumes one clock; sys_rst_in disables the checks.
`timescale 1ns/1ps
`default_nettype none
module lps_top_chk #(
	parameter TICK_CYCLES = 8
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// watched ports
	input wire logic negotiated_link_up_flag_in,
	input wire logic primary_indicator_oe_out,
	input wire logic secondary_indicator_oe_out,
	input wire logic link_up_indicator_pin_out,
	input wire logic link_up_indicator_pin_oe_out,
	input wire logic soft_powerdown_reached_out,
	input wire logic soft_powerdown_request_out,
	input wire logic hw_powerdown_out,
	input wire logic phy_enable_out,
	input wire logic pll_run_out,
	input wire logic regs_accessible_out,
	input wire logic autoneg_start_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	// flag edge while the phy stays up; polarity writes are kept apart by the bench
	sequence s_link_rise;
		$rose(negotiated_link_up_flag_in) && phy_enable_out ##1 phy_enable_out;
	endsequence
	link_follow_a: assert property (s_link_rise |-> $changed(link_up_indicator_pin_out))
		else $error("link pin missed flag");
	reset_quiet_a: assert property (hw_powerdown_out |-> !primary_indicator_oe_out
		&& !secondary_indicator_oe_out && !link_up_indicator_pin_oe_out && !regs_accessible_out)
		else $error("pins driven in power-down");
	boot_pins_a: assert property ($rose(regs_accessible_out) |-> primary_indicator_oe_out
		&& !secondary_indicator_oe_out) else $error("boot pin state wrong");
	softpd_state_a: assert property (soft_powerdown_reached_out |-> !phy_enable_out
		&& pll_run_out && regs_accessible_out) else $error("soft power-down state wrong");
	reached_track_a: assert property (regs_accessible_out && $past(regs_accessible_out)
		&& $stable(soft_powerdown_request_out) |-> soft_powerdown_reached_out == soft_powerdown_request_out)
		else $error("reached flag off request");
	autoneg_entry_a: assert property ($fell(soft_powerdown_request_out) && $past(regs_accessible_out)
		&& regs_accessible_out |-> autoneg_start_out) else $error("no autoneg start");
	autoneg_pulse_a: assert property (autoneg_start_out |=> !autoneg_start_out)
		else $error("autoneg start too long");
	enable_state_a: assert property (phy_enable_out |-> pll_run_out && regs_accessible_out
		&& !hw_powerdown_out) else $error("phy up while not active");
endmodule // lps_top_chk
bind lps_top lps_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock_in, .sys_rst_in,
	.negotiated_link_up_flag_in, .primary_indicator_oe_out, .secondary_indicator_oe_out,
	.link_up_indicator_pin_out, .link_up_indicator_pin_oe_out, .soft_powerdown_reached_out,
	.soft_powerdown_request_out, .hw_powerdown_out, .phy_enable_out, .pll_run_out,
	.regs_accessible_out, .autoneg_start_out);
`default_nettype wire

// ==== bench/lps_top_tb.sv ====
// lps_top_tb.sv: self-checking bench for lps_top.
// Assumes lps_map.vh on the include path and the board model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "lps_map.vh"
module lps_top_tb;
	logic        clock_in, sys_rst_in, rst_n, flag, act, strap, pd_wr, pd_req, cfg_wr, en, md, lpol;
	logic [1:0]  pol, mux;
	int          lit_p, lit_s;
	logic [3:0]  fn;
	logic        p_pin, p_lvl, p_oe, s_pin, s_lvl, s_oe, l_lvl, l_oe;
	logic        reached, req_o, hwpd, phy_en, pll, regs_ok, an_go;
	int          errors, checks_done;
	logic [31:0] seed;

	lps_top #(.TICK_CYCLES(8)) DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reset_pin_n_in(rst_n),
		.soft_reset_in(1'b0), .negotiated_link_up_flag_in(flag), .traffic_activity_in(act),
		.powerdown_after_reset_strap_in(strap), .soft_powerdown_wr_in(pd_wr), .soft_powerdown_request_in(pd_req),
		.indicator_control_wr_in(cfg_wr), .primary_indicator_enable_in(en), .secondary_indicator_enable_in(en),
		.primary_indicator_polarity_in(pol), .secondary_indicator_polarity_in(pol),
		.primary_indicator_blink_mode_in(md), .secondary_indicator_blink_mode_in(md),
		.primary_indicator_function_in(fn), .secondary_indicator_function_in(fn),
		.primary_indicator_on_off_time_in(16'h0101), .secondary_indicator_on_off_time_in(16'h0202),
		.secondary_indicator_mux_sel_in(mux), .link_indicator_polarity_in(lpol),
		.primary_indicator_pin_in(p_pin), .primary_indicator_out(p_lvl), .primary_indicator_oe_out(p_oe),
		.secondary_indicator_pin_in(s_pin), .secondary_indicator_out(s_lvl), .secondary_indicator_oe_out(s_oe),
		.link_up_indicator_pin_out(l_lvl), .link_up_indicator_pin_oe_out(l_oe),
		.soft_powerdown_reached_out(reached), .soft_powerdown_request_out(req_o), .hw_powerdown_out(hwpd),
		.phy_enable_out(phy_en), .pll_run_out(pll), .regs_accessible_out(regs_ok), .autoneg_start_out(an_go));
	lps_led_model u_leds (.pri_lvl_in(p_lvl), .pri_oe_in(p_oe), .sec_lvl_in(s_lvl), .sec_oe_in(s_oe),
		.pri_pin_out(p_pin), .sec_pin_out(s_pin));

	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction
	// lit level seen at the pin for an explicit polarity
	function automatic logic exp_pin(input logic [1:0] p, input logic lit);
		exp_pin = lit ^ (p == `LPS_POL_LOW);
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			errors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// inputs change 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic boot(input logic s);
		strap = s;
		sys_rst_in = 1'b1;
		tick(12);
		sys_rst_in = 1'b0;
		for (int i = 0; i < 400 && regs_ok !== 1'b1; i++)
			tick(1);
		if (regs_ok !== 1'b1) begin
			errors++;
			wrap_up();
		end
	endtask
	task automatic cfg(input logic e, input logic [1:0] p, input logic m, input logic [3:0] f, input logic lp);
		{en, pol, md, fn, lpol} = {e, p, m, f, lp};
		cfg_wr = 1'b1;
		tick(1);
		cfg_wr = 1'b0;
		tick(4);
	endtask
	task automatic pd(input logic r);
		pd_req = r;
		pd_wr = 1'b1;
		tick(1);
		pd_wr = 1'b0;
		tick(4);
		check(reached, r);
		check(phy_en, !r);
		check(l_lvl, (flag & !r) ^ lpol);
	endtask

	initial begin
		{rst_n, flag, act, pd_wr, pd_req, cfg_wr, en, md, lpol, pol, fn} = 15'h4000;
		{sys_rst_in, strap, errors, checks_done, mux} = 0;
		seed = 32'h00007F22;
		// unmanaged board straps power-down-after-reset off
		boot(1'b1);
		check(req_o, 1'b0);
		check(phy_en, 1'b1);
		check({p_oe, s_oe}, 2'h2);
		// the sensed polarity reaches the pin one edge after the enables rise
		tick(1);
		check(p_lvl, 1'b1);
		flag = 1'b1;
		tick(2);
		check({l_oe, l_lvl}, 2'h3);
		for (int i = 0; i < 10; i++) begin
			seed = xs(seed);
			act = seed[4];
			mux = seed[5] ? `LPS_MUX_INDICATOR : `LPS_MUX_OFF;
			cfg(seed[2] | (i < 2), seed[0] ? `LPS_POL_HIGH : `LPS_POL_LOW, `LPS_MODE_TIMED,
				seed[1] ? `LPS_FN_FORCE_ON : `LPS_FN_FORCE_OFF, seed[3]);
			check(p_lvl, exp_pin(pol, en & (fn == `LPS_FN_FORCE_ON)));
			check({s_oe, s_lvl}, {seed[5], exp_pin(pol, en & (fn == `LPS_FN_FORCE_ON))});
			check(l_lvl, !lpol);
		end
		mux = `LPS_MUX_INDICATOR;
		for (int f = 7; f <= 10; f++) begin
			cfg(1'b1, `LPS_POL_HIGH, `LPS_MODE_AUTO_DUTY, 4'(f), 1'b0);
			check(p_lvl, 1'b0);
		end
		// free blink: phase lasts time+1 ticks, so half of any whole number of periods is lit
		cfg(1'b1, `LPS_POL_HIGH, `LPS_MODE_TIMED, `LPS_FN_FREE_BLINK, 1'b0);
		tick(32);
		{lit_p, lit_s} = 0;
		for (int i = 0; i < 96; i++) begin
			lit_p += p_lvl;
			lit_s += s_lvl;
			tick(1);
		end
		check(8'(lit_p), 8'h30);
		check(8'(lit_s), 8'h30);
		pd(1'b1);
		pd(1'b0);
		rst_n = 1'b0;
		tick(5);
		check({hwpd, p_oe, regs_ok}, 3'h4);
		rst_n = 1'b1;
		boot(1'b0);
		check({req_o, reached}, 2'h3);
		pd(1'b0);
		wrap_up();
	end
endmodule // lps_top_tb
`default_nettype wire

// ==== src/lps_blink.v ====
// lps_blink.v: one indicator's lit/unlit generator and pin level.
// Assumes a one-cycle tick from the parent time base, same clock.
`timescale 1ns/1ps
`default_nettype none
`include "lps_map.vh"

module lps_blink (
	// clock and reset
	input  wire       clock_in,
	input  wire       sys_rst_in,
	// time base and status
	input  wire       tick_in,
	input  wire       link_in,
	input  wire       activity_in,
	// configuration
	input  wire       enable_in,
	input  wire       active_low_in,
	input  wire       mode_in,
	input  wire [3:0] function_in,
	input  wire [7:0] on_time_in,
	input  wire [7:0] off_time_in,
	// pin level
	output reg        level_out
);

	reg       act_seen_reg;
	reg       blinking_reg;
	reg       on_phase_reg;
	reg [7:0] phase_cnt_reg;
	reg [7:0] win_cnt_reg;
	reg [7:0] act_ticks_reg;
	reg [7:0] pct_reg;
	reg       base_lit;
	reg       blink_wanted;
	reg       lit;

	// ----------------------------------------------------------------
	// function decode
	// ----------------------------------------------------------------
	always @* begin
		base_lit     = 1'b0;
		blink_wanted = 1'b0;
		case (function_in)
			`LPS_FN_LINK_TRAFFIC: begin
				base_lit     = link_in;
				blink_wanted = link_in;
			end
			`LPS_FN_TRAFFIC_ONLY: blink_wanted = 1'b1;
			`LPS_FN_LINK_ONLY:    base_lit     = link_in;
			`LPS_FN_FORCE_ON:     base_lit     = 1'b1;
			default:              base_lit     = 1'b0;
		endcase
	end

	// activity is caught between ticks so short bursts still blink
	always @(posedge clock_in) begin
		if (sys_rst_in)
			act_seen_reg <= 1'b0;
		else if (activity_in)
			act_seen_reg <= 1'b1;
		else if (tick_in)
			act_seen_reg <= 1'b0;
	end

	always @(posedge clock_in) begin
		if (sys_rst_in) begin
			blinking_reg  <= 1'b0;
			on_phase_reg  <= 1'b0;
			phase_cnt_reg <= 8'h00;
		end else if (tick_in) begin
			if (!blinking_reg) begin
				blinking_reg  <= act_seen_reg | (function_in == `LPS_FN_FREE_BLINK);
				on_phase_reg  <= 1'b0;
				phase_cnt_reg <= 8'h00;
			end else if (on_phase_reg ? (phase_cnt_reg >= on_time_in) : (phase_cnt_reg >= off_time_in)) begin
				// a blink cycle ends after the off phase only if no more traffic
				on_phase_reg  <= ~on_phase_reg;
				phase_cnt_reg <= 8'h00;
				if (!on_phase_reg && !act_seen_reg && function_in != `LPS_FN_FREE_BLINK)
					blinking_reg <= 1'b0;
			end else begin
				phase_cnt_reg <= phase_cnt_reg + 8'h01;
			end
		end
	end

	always @(posedge clock_in) begin
		if (sys_rst_in) begin
			win_cnt_reg   <= 8'h00;
			act_ticks_reg <= 8'h00;
			pct_reg       <= 8'h00;
		end else if (tick_in) begin
			if (win_cnt_reg == `LPS_DUTY_WINDOW - 8'h01) begin
				win_cnt_reg   <= 8'h00;
				pct_reg       <= act_ticks_reg + {7'h00, act_seen_reg};
				act_ticks_reg <= 8'h00;
			end else begin
				win_cnt_reg   <= win_cnt_reg + 8'h01;
				act_ticks_reg <= act_ticks_reg + {7'h00, act_seen_reg};
			end
		end
	end

	// lit decision per mode
	always @* begin
		if (mode_in == `LPS_MODE_TIMED) begin
			lit = (blinking_reg && (blink_wanted || function_in == `LPS_FN_FREE_BLINK)) ? on_phase_reg : base_lit;
		end else if (function_in >= `LPS_FN_NO_DUTY_LO && function_in <= `LPS_FN_NO_DUTY_HI) begin
			lit = 1'b0;
		end else begin
			lit = (blink_wanted && pct_reg != 8'h00) ? (win_cnt_reg < pct_reg) : base_lit;
		end
	end

	always @(posedge clock_in) begin
		if (sys_rst_in)
			level_out <= 1'b0;
		else
			level_out <= enable_in ? (lit ^ active_low_in) : active_low_in;
	end

endmodule // lps_blink

`default_nettype wire

// ==== src/lps_map.vh ====
// lps_map.vh: constants for the indicator and power-state block.
// Assumes inclusion by the design files of the lps block and by its bench.
`ifndef LPS_MAP_VH
`define LPS_MAP_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LPS_CLK_PERIOD_NS     4
`define LPS_STRAP_SETTLE_NS   1000
`define LPS_STRAP_SETTLE_CYC  ((`LPS_STRAP_SETTLE_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)
`define LPS_TICK_NS           1000000
`define LPS_TICK_CYC          (`LPS_TICK_NS / `LPS_CLK_PERIOD_NS)
`define LPS_DUTY_WINDOW       8'h64

// ----------------------------------------------------------------
// polarity codes
// ----------------------------------------------------------------
`define LPS_POL_AUTO          2'h0
`define LPS_POL_HIGH          2'h1
`define LPS_POL_LOW           2'h2

// ----------------------------------------------------------------
// blink modes
// ----------------------------------------------------------------
`define LPS_MODE_TIMED        1'h0
`define LPS_MODE_AUTO_DUTY    1'h1

// ----------------------------------------------------------------
// indicator function codes
// ----------------------------------------------------------------
`define LPS_FN_LINK_TRAFFIC   4'h0
`define LPS_FN_TRAFFIC_ONLY   4'h1
`define LPS_FN_LINK_ONLY      4'h2
`define LPS_FN_FORCE_ON       4'h3
`define LPS_FN_FORCE_OFF      4'h4
`define LPS_FN_FREE_BLINK     4'h7
`define LPS_FN_NO_DUTY_LO     4'h7
`define LPS_FN_NO_DUTY_HI     4'hA

// ----------------------------------------------------------------
// secondary pin mux selections
// ----------------------------------------------------------------
`define LPS_MUX_OFF           2'h0
`define LPS_MUX_INDICATOR     2'h1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LPS_RST_ENABLE        1'h1
`define LPS_RST_POLARITY      `LPS_POL_AUTO
`define LPS_RST_MODE          `LPS_MODE_TIMED
`define LPS_RST_PRI_FUNCTION  `LPS_FN_LINK_TRAFFIC
`define LPS_RST_SEC_FUNCTION  `LPS_FN_TRAFFIC_ONLY
`define LPS_RST_ON_OFF_TIME   16'h3232
`define LPS_RST_MUX_SEL       `LPS_MUX_OFF
`define LPS_RST_LINK_POL      1'h0

`endif

// ==== src/lps_sync.v ====
// lps_sync.v: two-flop synchroniser for pin levels.
// Assumes inputs are asynchronous; only the second stage is read.
`timescale 1ns/1ps
`default_nettype none

module lps_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clock_in,
	input  wire             sys_rst_in,
	// levels
	input  wire [WIDTH-1:0] async_in,
	input  wire [WIDTH-1:0] rst_val_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_reg;

	// first stage feeds the second stage only
	always @(posedge clock_in) begin
		if (sys_rst_in) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

	// rst_val_in unused by design: constant-only reset keeps the flops clean
	wire unused_rst_val = |rst_val_in;

endmodule // lps_sync

`default_nettype wire

// ==== src/lps_top.v ====
// lps_top.v: indicator pins, link pin, strap sampling and power states.
// Assumes control inputs come from management logic on clock_in;
// pins and straps are asynchronous and pass the synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "lps_map.vh"

// Summary of operation
// - after reset primary indicator enabled, secondary held off by its mux
// - secondary pin driven only when mux select picks the indicator
// - primary indicator drives its pin with no mux
// - per-indicator polarity: autosense default, active high or active low
// - autosense picks polarity from pin level sampled at end of the settle time after reset
// - active high lit means pin high; active low lit means pin low
// - timed mode uses each indicator's on/off time setting
// - automatic mode sets duty from measured activity percentage
// - function codes 7 to 10 unsupported in automatic mode
// - both timed mode; primary link plus traffic, secondary traffic only
// - link pin asserted while negotiated link flag is set
// - link pin active high by default, polarity bit inverts it
// - reset pin low: hardware power-down, pins tristated, writes ignored
// - soft power-down entered by strap after reset or by request
// - readable flag shows soft power-down actually reached
// - soft power-down ignores line, no link, clock and registers kept
// - clearing request leaves power-down and starts autonegotiation
// - straps sampled at end of the settle time after any reset, settings loaded
// - after sampling pins return to normal use, link bring-up starts
// - host writes override strap-derived settings
// - strap low means soft power-down after reset, high means active
module lps_top #(
	parameter TICK_CYCLES = `LPS_TICK_CYC
) (
	// clock and resets
	input  wire        clock_in,
	input  wire        sys_rst_in,
	input  wire        reset_pin_n_in,
	input  wire        soft_reset_in,
	// link status from the phy
	input  wire        negotiated_link_up_flag_in,
	input  wire        traffic_activity_in,
	// strap pin
	input  wire        powerdown_after_reset_strap_in,
	// soft power-down control
	input  wire        soft_powerdown_wr_in,
	input  wire        soft_powerdown_request_in,
	// indicator configuration write
	input  wire        indicator_control_wr_in,
	input  wire        primary_indicator_enable_in,
	input  wire        secondary_indicator_enable_in,
	input  wire [1:0]  primary_indicator_polarity_in,
	input  wire [1:0]  secondary_indicator_polarity_in,
	input  wire        primary_indicator_blink_mode_in,
	input  wire        secondary_indicator_blink_mode_in,
	input  wire [3:0]  primary_indicator_function_in,
	input  wire [3:0]  secondary_indicator_function_in,
	input  wire [15:0] primary_indicator_on_off_time_in,
	input  wire [15:0] secondary_indicator_on_off_time_in,
	input  wire [1:0]  secondary_indicator_mux_sel_in,
	input  wire        link_indicator_polarity_in,
	// indicator pins
	input  wire        primary_indicator_pin_in,
	output reg         primary_indicator_out,
	output reg         primary_indicator_oe_out,
	input  wire        secondary_indicator_pin_in,
	output reg         secondary_indicator_out,
	output reg         secondary_indicator_oe_out,
	// link pin
	output reg         link_up_indicator_pin_out,
	output reg         link_up_indicator_pin_oe_out,
	// power state
	output reg         soft_powerdown_reached_out,
	output reg         soft_powerdown_request_out,
	output reg         hw_powerdown_out,
	output reg         phy_enable_out,
	output reg         pll_run_out,
	output reg         regs_accessible_out,
	output reg         autoneg_start_out
);

	localparam ST_SETTLE = 1'b0;
	localparam ST_ACTIVE = 1'b1;
	localparam integer SETTLE_END = `LPS_STRAP_SETTLE_CYC - 1;
	localparam [15:0] SETTLE_LAST = SETTLE_END[15:0];
	localparam [31:0] TICK_LAST   = TICK_CYCLES - 1;

	wire [3:0] pins_sync;
	wire       rst_pin_n_s;
	wire       strap_s;
	wire       pri_pin_s;
	wire       sec_pin_s;
	wire       any_rst;
	wire       pri_level;
	wire       sec_level;

	reg        state_reg;
	reg [15:0] settle_cnt_reg;
	reg [31:0] tick_cnt_reg;
	reg        tick_reg;
	reg        pd_reg;
	reg        pri_sensed_low_reg;
	reg        sec_sensed_low_reg;
	reg        pri_en_reg;
	reg        sec_en_reg;
	reg [1:0]  pri_pol_reg;
	reg [1:0]  sec_pol_reg;
	reg        pri_mode_reg;
	reg        sec_mode_reg;
	reg [3:0]  pri_fn_reg;
	reg [3:0]  sec_fn_reg;
	reg [15:0] pri_time_reg;
	reg [15:0] sec_time_reg;
	reg [1:0]  mux_sel_reg;
	reg        link_pol_reg;
	reg        link_qual;

	// polarity resolution, used for both indicators
	function active_low_of;
		input [1:0] pol;
		input       sensed_low;
		begin
			active_low_of = (pol == `LPS_POL_LOW) | ((pol == `LPS_POL_AUTO) & sensed_low);
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	lps_sync #(
		.WIDTH (4)
	) u_sync (
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.async_in   ({reset_pin_n_in, powerdown_after_reset_strap_in,
		              primary_indicator_pin_in, secondary_indicator_pin_in}),
		.rst_val_in (4'h0),
		.sync_out   (pins_sync)
	);

	assign rst_pin_n_s = pins_sync[3];
	assign strap_s     = pins_sync[2];
	assign pri_pin_s   = pins_sync[1];
	assign sec_pin_s   = pins_sync[0];

	// pin held low acts as a reset; sync stage reads low until first edges
	assign any_rst = sys_rst_in | ~rst_pin_n_s | soft_reset_in;

	// ----------------------------------------------------------------
	// strap sampling sequence
	// ----------------------------------------------------------------
	// pins float for a settle time so pulls and straps reach a level
	always @(posedge clock_in) begin
		if (any_rst) begin
			state_reg      <= ST_SETTLE;
			settle_cnt_reg <= 16'h0000;
		end else begin
			case (state_reg)
				ST_SETTLE: begin
					if (settle_cnt_reg == SETTLE_LAST)
						state_reg <= ST_ACTIVE;
					else
						settle_cnt_reg <= settle_cnt_reg + 16'h0001;
				end
				default: state_reg <= ST_ACTIVE;
			endcase
		end
	end

	// capture strap and sense levels at end of settle
	always @(posedge clock_in) begin
		if (any_rst) begin
			pri_sensed_low_reg <= 1'b0;
			sec_sensed_low_reg <= 1'b0;
		end else if (state_reg == ST_SETTLE && settle_cnt_reg == SETTLE_LAST) begin
			// a pin pulled high means the led hangs from supply
			pri_sensed_low_reg <= pri_pin_s;
			sec_sensed_low_reg <= sec_pin_s;
		end
	end

	// ----------------------------------------------------------------
	// soft power-down request
	// ----------------------------------------------------------------
	// strap loads the request; a later host write always wins
	always @(posedge clock_in) begin
		if (any_rst) begin
			pd_reg <= 1'b1;
		end else if (state_reg == ST_SETTLE && settle_cnt_reg == SETTLE_LAST) begin
			pd_reg <= ~strap_s;
		end else if (state_reg == ST_ACTIVE && soft_powerdown_wr_in) begin
			pd_reg <= soft_powerdown_request_in;
		end
	end

	// ----------------------------------------------------------------
	// indicator configuration
	// ----------------------------------------------------------------
	// writes land only once registers are reachable
	always @(posedge clock_in) begin
		if (any_rst) begin
			pri_en_reg   <= `LPS_RST_ENABLE;
			sec_en_reg   <= `LPS_RST_ENABLE;
			pri_pol_reg  <= `LPS_RST_POLARITY;
			sec_pol_reg  <= `LPS_RST_POLARITY;
			pri_mode_reg <= `LPS_RST_MODE;
			sec_mode_reg <= `LPS_RST_MODE;
			pri_fn_reg   <= `LPS_RST_PRI_FUNCTION;
			sec_fn_reg   <= `LPS_RST_SEC_FUNCTION;
			pri_time_reg <= `LPS_RST_ON_OFF_TIME;
			sec_time_reg <= `LPS_RST_ON_OFF_TIME;
			mux_sel_reg  <= `LPS_RST_MUX_SEL;
			link_pol_reg <= `LPS_RST_LINK_POL;
		end else if (state_reg == ST_ACTIVE && indicator_control_wr_in) begin
			pri_en_reg   <= primary_indicator_enable_in;
			sec_en_reg   <= secondary_indicator_enable_in;
			pri_pol_reg  <= primary_indicator_polarity_in;
			sec_pol_reg  <= secondary_indicator_polarity_in;
			pri_mode_reg <= primary_indicator_blink_mode_in;
			sec_mode_reg <= secondary_indicator_blink_mode_in;
			pri_fn_reg   <= primary_indicator_function_in;
			sec_fn_reg   <= secondary_indicator_function_in;
			pri_time_reg <= primary_indicator_on_off_time_in;
			sec_time_reg <= secondary_indicator_on_off_time_in;
			mux_sel_reg  <= secondary_indicator_mux_sel_in;
			link_pol_reg <= link_indicator_polarity_in;
		end
	end

	// ----------------------------------------------------------------
	// blink time base
	// ----------------------------------------------------------------
	// one tick per period; blink counts are in ticks to keep them narrow
	always @(posedge clock_in) begin
		if (any_rst) begin
			tick_cnt_reg <= 32'h00000000;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == TICK_LAST) begin
			tick_cnt_reg <= 32'h00000000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
			tick_reg     <= 1'b0;
		end
	end

	// line status is ignored during soft power-down
	always @* begin
		link_qual = negotiated_link_up_flag_in & ~pd_reg & (state_reg == ST_ACTIVE);
	end

	// ----------------------------------------------------------------
	// indicator generators
	// ----------------------------------------------------------------
	lps_blink u_pri (
		.clock_in      (clock_in),
		.sys_rst_in    (any_rst),
		.tick_in       (tick_reg),
		.link_in       (link_qual),
		.activity_in   (traffic_activity_in & link_qual),
		.enable_in     (pri_en_reg),
		.active_low_in (active_low_of(pri_pol_reg, pri_sensed_low_reg)),
		.mode_in       (pri_mode_reg),
		.function_in   (pri_fn_reg),
		.on_time_in    (pri_time_reg[15:8]),
		.off_time_in   (pri_time_reg[7:0]),
		.level_out     (pri_level)
	);

	lps_blink u_sec (
		.clock_in      (clock_in),
		.sys_rst_in    (any_rst),
		.tick_in       (tick_reg),
		.link_in       (link_qual),
		.activity_in   (traffic_activity_in & link_qual),
		.enable_in     (sec_en_reg),
		.active_low_in (active_low_of(sec_pol_reg, sec_sensed_low_reg)),
		.mode_in       (sec_mode_reg),
		.function_in   (sec_fn_reg),
		.on_time_in    (sec_time_reg[15:8]),
		.off_time_in   (sec_time_reg[7:0]),
		.level_out     (sec_level)
	);

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	// pins drive only after the straps are taken
	always @(posedge clock_in) begin
		if (any_rst) begin
			primary_indicator_out        <= 1'b0;
			primary_indicator_oe_out     <= 1'b0;
			secondary_indicator_out      <= 1'b0;
			secondary_indicator_oe_out   <= 1'b0;
			link_up_indicator_pin_out    <= 1'b0;
			link_up_indicator_pin_oe_out <= 1'b0;
		end else begin
			primary_indicator_out        <= pri_level;
			primary_indicator_oe_out     <= (state_reg == ST_ACTIVE);
			secondary_indicator_out      <= sec_level;
			secondary_indicator_oe_out   <= (state_reg == ST_ACTIVE) && (mux_sel_reg == `LPS_MUX_INDICATOR);
			link_up_indicator_pin_out    <= link_qual ^ link_pol_reg;
			link_up_indicator_pin_oe_out <= (state_reg == ST_ACTIVE);
		end
	end

	// ----------------------------------------------------------------
	// power state outputs
	// ----------------------------------------------------------------
	// autoneg kick on leaving power-down or active start
	always @(posedge clock_in) begin
		if (any_rst) begin
			soft_powerdown_reached_out <= 1'b0;
			soft_powerdown_request_out <= 1'b0;
			hw_powerdown_out           <= 1'b1;
			phy_enable_out             <= 1'b0;
			pll_run_out                <= 1'b0;
			regs_accessible_out        <= 1'b0;
			autoneg_start_out          <= 1'b0;
		end else begin
			// reached only once active and power-down in force
			soft_powerdown_reached_out <= (state_reg == ST_ACTIVE) & pd_reg;
			soft_powerdown_request_out <= pd_reg;
			hw_powerdown_out           <= 1'b0;
			// pll and register access kept in soft power-down
			phy_enable_out             <= (state_reg == ST_ACTIVE) & ~pd_reg;
			pll_run_out                <= (state_reg == ST_ACTIVE);
			regs_accessible_out        <= (state_reg == ST_ACTIVE);
			autoneg_start_out          <= (state_reg == ST_ACTIVE) & ~pd_reg & ~phy_enable_out;
		end
	end

endmodule // lps_top

`default_nettype wire
